// *** shared/cmsp_defines.vh ***
// constants for the cellular serial port host controller
`ifndef CMSP_DEFINES_VH
`define CMSP_DEFINES_VH
// ---------------------------------------------------------------
// clock and line timing
// ---------------------------------------------------------------
`define CMSP_CLK_HZ 50000000
`define CMSP_BAUD_DEFAULT 115200
`define CMSP_DIV_DEFAULT (`CMSP_CLK_HZ / `CMSP_BAUD_DEFAULT)
`define CMSP_DATA_BITS 8
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CMSP_REG_CTRL 4'h0
`define CMSP_REG_STAT 4'h4
`define CMSP_REG_TXD 4'h8
`define CMSP_REG_RXD 4'hC
`define CMSP_ADDR_W 4
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CMSP_CTRL_DIV_LSB 0
`define CMSP_CTRL_DIV_MSB 15
`define CMSP_CTRL_RTS_ON 16
`define CMSP_CTRL_DTR_ON 17
`define CMSP_CTRL_AUX 18
`define CMSP_CTRL_FC_EN 19
// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define CMSP_STAT_RX_VALID 0
`define CMSP_STAT_TX_READY 1
`define CMSP_STAT_FRAME_ERR 2
`define CMSP_STAT_CTS_ON 3
`define CMSP_STAT_DSR_ON 4
`define CMSP_STAT_DCD_ON 5
`define CMSP_STAT_RI_ON 6
`define CMSP_STAT_TX_BUSY 7
`endif

// *** logic/cmsp_fifo.v ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cmsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg out_valid_q;
  wire push;
  wire pop_mem;
  wire [AW-1:0] wr_next;
  wire [AW-1:0] rd_next;

  // output register counts as one extra slot
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid_i & in_ready_o;
  assign out_valid_o = out_valid_q;
  assign pop_mem = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready_i);
  assign wr_next = (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
  assign rd_next = (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;

  // storage array, no reset needed
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers, count and registered read data
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_next;
      end
      if (pop_mem) begin
        rd_q <= rd_next;
        out_data_o <= mem_q[rd_q];
        out_valid_q <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_q <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
    end
  end
endmodule // cmsp_fifo

// *** logic/cmsp_uart_rx.v ***
// 8n1 receiver with centre sampling and stop-bit check
`timescale 1ns/1ps
`include "cmsp_defines.vh"
module cmsp_uart_rx #(
  parameter DIV_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // line and rate
  input wire rx_i,
  input wire [DIV_W-1:0] div_i,
  // received character
  output reg [7:0] data_o,
  output reg valid_o,
  output reg frame_err_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_STOP = 3'b100;
  reg [2:0] state_q;
  reg [DIV_W-1:0] cnt_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg rx_prev_q;

  // first wait spans one and a half bits to reach the centre of bit 0;
  // a divider above two thirds of the counter range would overflow it
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      rx_prev_q <= 1'b1;
      cnt_q <= {DIV_W{1'b0}};
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      data_o <= 8'h00;
      valid_o <= 1'b0;
      frame_err_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      frame_err_o <= 1'b0;
      // reset value is the idle level, so no false edge follows reset
      rx_prev_q <= rx_i;
      case (state_q)
        ST_IDLE: begin
          // only a falling edge starts a frame, so a line held low
          // after a bad stop bit is not taken as a new character
          if (!rx_i && rx_prev_q) begin
            cnt_q <= div_i + {1'b0, div_i[DIV_W-1:1]} - 1'b1;
            bit_q <= 3'd0;
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (cnt_q != {DIV_W{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cnt_q <= div_i - 1'b1;
            // data bits taken at their centre
            sh_q <= {rx_i, sh_q[7:1]};
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              state_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (cnt_q != {DIV_W{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            state_q <= ST_IDLE;
            if (rx_i) begin
              data_o <= sh_q;
              valid_o <= 1'b1;
            end else begin
              frame_err_o <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // cmsp_uart_rx

// *** logic/cmsp_host.v ***
// host-side controller for the cellular module serial port
`timescale 1ns/1ps
`include "cmsp_defines.vh"
// Function
// - default rate 115200 after reset
// - frames are start, eight data, stop
// - low level means zero or ON
// - host drives TXD RTS DTR only
// - aux port remaps DCD DTR RI; DSR stays a status input only
// - host holds RTS ON to exchange
// - host holds DTR ON for unsolicited messages
// - mux framing carried as plain bytes
// - mux channel numbers live in software
// - dial-up stack runs in host software
module cmsp_host #(
  parameter DIV_W = 16,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`CMSP_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // main port pins toward the module
  output reg txd_o,
  output reg rts_n_o,
  output reg dtr_n_o,
  input wire rxd_i,
  input wire cts_n_i,
  input wire dsr_n_i,
  input wire dcd_n_i,
  input wire ri_n_i
);
  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  reg [DIV_W-1:0] div_q;
  reg rts_on_q;
  reg dtr_on_q;
  reg aux_q;
  reg fc_en_q;
  reg frame_err_q;
  reg [7:0] rx_data_q;
  reg rx_valid_q;
  reg tx_busy_q;
  // reset divider, cut to the register width on purpose
  localparam [31:0] DIV_RST = `CMSP_DIV_DEFAULT;
  wire wb_req;
  wire wr_ctrl;
  wire wr_txd;
  wire rd_rxd;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire tx_take;
  wire [7:0] rx_data;
  wire rx_valid;
  wire rx_err;
  wire rx_line;
  wire cts_on;
  reg [31:0] rd_mux;

  // single-cycle ack, dropped the cycle after
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == `CMSP_REG_CTRL);
  assign wr_txd = wb_req & wb_we_i & (wb_adr_i == `CMSP_REG_TXD) & wb_sel_i[0];
  assign rd_rxd = wb_req & ~wb_we_i & (wb_adr_i == `CMSP_REG_RXD);

  // aux port uses DCD as data and RI as flow control
  assign rx_line = aux_q ? dcd_n_i : rxd_i;
  // low level on flow line means ON
  assign cts_on = aux_q ? ~ri_n_i : ~cts_n_i;

  // status and data readback
  always @* begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `CMSP_REG_CTRL: begin
        rd_mux[`CMSP_CTRL_DIV_MSB:`CMSP_CTRL_DIV_LSB] = div_q;
        rd_mux[`CMSP_CTRL_RTS_ON] = rts_on_q;
        rd_mux[`CMSP_CTRL_DTR_ON] = dtr_on_q;
        rd_mux[`CMSP_CTRL_AUX] = aux_q;
        rd_mux[`CMSP_CTRL_FC_EN] = fc_en_q;
      end
      `CMSP_REG_STAT: begin
        rd_mux[`CMSP_STAT_RX_VALID] = rx_valid_q;
        rd_mux[`CMSP_STAT_TX_READY] = fifo_in_ready;
        rd_mux[`CMSP_STAT_FRAME_ERR] = frame_err_q;
        rd_mux[`CMSP_STAT_CTS_ON] = ~cts_n_i;
        rd_mux[`CMSP_STAT_DSR_ON] = ~dsr_n_i;
        rd_mux[`CMSP_STAT_DCD_ON] = ~dcd_n_i;
        rd_mux[`CMSP_STAT_RI_ON] = ~ri_n_i;
        rd_mux[`CMSP_STAT_TX_BUSY] = fifo_out_valid | tx_busy_q;
      end
      `CMSP_REG_RXD: begin
        rd_mux[7:0] = rx_data_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // bus answer and control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      div_q <= DIV_RST[DIV_W-1:0];
      rts_on_q <= 1'b0;
      dtr_on_q <= 1'b0;
      aux_q <= 1'b0;
      fc_en_q <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
      if (wr_ctrl) begin
        if (wb_sel_i[0]) div_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) div_q[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) begin
          rts_on_q <= wb_dat_i[`CMSP_CTRL_RTS_ON];
          dtr_on_q <= wb_dat_i[`CMSP_CTRL_DTR_ON];
          aux_q <= wb_dat_i[`CMSP_CTRL_AUX];
          fc_en_q <= wb_dat_i[`CMSP_CTRL_FC_EN];
        end
      end
    end
  end

  // -------------------------------------------------------------
  // modem control outputs
  // -------------------------------------------------------------
  reg tx_line_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      txd_o <= 1'b1;
    end else begin
      // aux: DTR carries data, RTS keeps carrying host flow control
      dtr_n_o <= aux_q ? tx_line_q : ~dtr_on_q;
      rts_n_o <= ~rts_on_q;
      txd_o <= aux_q ? 1'b1 : tx_line_q;
    end
  end

  // -------------------------------------------------------------
  // transmit path
  // -------------------------------------------------------------
  // mux frames pass as bytes
  cmsp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_txfifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_txd),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wb_dat_i[7:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tx_take),
    .out_data_o(fifo_out_data)
  );

  reg [DIV_W-1:0] tx_cnt_q;
  reg [3:0] tx_bit_q;
  reg [9:0] tx_sh_q;
  // flow control stalls only new characters, never one in flight
  assign tx_take = fifo_out_valid & ~tx_busy_q & (~fc_en_q | cts_on);

  // ten-bit frame: start, eight lsb-first, stop
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= {DIV_W{1'b0}};
      tx_bit_q <= 4'd0;
      tx_sh_q <= 10'h3FF;
      tx_line_q <= 1'b1;
    end else if (tx_take) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= div_q - 1'b1;
      tx_bit_q <= 4'd0;
      tx_sh_q <= {1'b1, fifo_out_data, 1'b0};
      tx_line_q <= 1'b0;
    end else if (tx_busy_q) begin
      if (tx_cnt_q != {DIV_W{1'b0}}) begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end else begin
        tx_cnt_q <= div_q - 1'b1;
        tx_bit_q <= tx_bit_q + 4'd1;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_line_q <= tx_sh_q[1];
        if (tx_bit_q == 4'd9) begin
          tx_busy_q <= 1'b0;
          tx_line_q <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // receive path
  // -------------------------------------------------------------
  cmsp_uart_rx #(
    .DIV_W(DIV_W)
  ) u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_i(rx_line),
    .div_i(div_q),
    .data_o(rx_data),
    .valid_o(rx_valid),
    .frame_err_o(rx_err)
  );

  // received byte holding; new byte wins over a read clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      if (rx_valid) begin
        rx_data_q <= rx_data;
        rx_valid_q <= 1'b1;
      end else if (rd_rxd) begin
        rx_valid_q <= 1'b0;
      end
      // sticky, cleared by writing one to it
      if (rx_err) begin
        frame_err_q <= 1'b1;
      end else if (wb_req && wb_we_i && wb_adr_i == `CMSP_REG_STAT && wb_sel_i[0]
                   && wb_dat_i[`CMSP_STAT_FRAME_ERR]) begin
        frame_err_q <= 1'b0;
      end
    end
  end
endmodule // cmsp_host

// *** verification/cmsp_host_asserts.sv ***
// port checker for the cellular serial port host controller
`timescale 1ns/1ps
module cmsp_host_asserts (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins
  input wire txd_o,
  input wire rts_n_o,
  input wire dtr_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[1:0] != 2'b00)
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  // ----------------------------------------
  // line pins
  // ----------------------------------------
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> txd_o && rts_n_o && dtr_n_o)
    else $error("pins not off after reset");
  start_len_a: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("start bit too short");
  rts_cause_a: assert property ($changed(rts_n_o) |-> $past(wb_cyc_i && wb_we_i))
    else $error("rts moved without a write");
  dtr_cause_a: assert property ($changed(dtr_n_o) |-> $past(wb_cyc_i && wb_we_i))
    else $error("dtr moved without a write");
  // main scenarios reached
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_start: cover property ($fell(txd_o));
  c_rts_on: cover property ($fell(rts_n_o));
endmodule // cmsp_host_asserts

// *** verification/cmsp_dev_model.sv ***
// behavioural model of the cellular module side of the serial port
`timescale 1ns/1ps
module cmsp_dev_model (
  // clock
  input wire clk_i,
  // pins from the host
  input wire txd_i,
  input wire rts_n_i,
  input wire dtr_n_i,
  // pins to the host
  output logic rxd_o,
  output wire [3:0] st_n_o,
  // scenario controls
  input wire [15:0] div_i,
  input wire [3:0] st_n_i,
  input wire bad_i,
  input wire msg_i
);
  logic [7:0] q[$];
  logic [7:0] b;
  logic [7:0] t;
  // device-driven status lines, low is on
  assign st_n_o = st_n_i;
  // serial port is the sole command path
  // rate set by the bench, never guessed
  always begin
    @(posedge clk_i);
    if (txd_i === 1'b0) begin
      repeat (div_i / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (div_i) @(posedge clk_i);
        b[i] = (txd_i !== 1'b0);
      end
      repeat (div_i) @(posedge clk_i);
      if (txd_i !== 1'b0 && !rts_n_i) q.push_back(b);
    end
  end
  // messages withheld while dtr is off
  always @(posedge clk_i) if (msg_i && !dtr_n_i) q.push_back(8'h5A);
  // idle high, start, lsb first, one stop
  initial rxd_o = 1'b1;
  always begin
    @(posedge clk_i);
    if (q.size() > 0) begin
      t = q.pop_front();
      rxd_o <= 1'b0;
      repeat (div_i) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        rxd_o <= t[i];
        repeat (div_i) @(posedge clk_i);
      end
      rxd_o <= ~bad_i;
      repeat (div_i) @(posedge clk_i);
      rxd_o <= 1'b1;
    end
  end
endmodule // cmsp_dev_model

// *** verification/tb_top.sv ***
// self-checking bench for the cellular serial port host controller
`timescale 1ns/1ps
`include "cmsp_defines.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] dw = 32'h0000_0000;
  logic [31:0] dr;
  logic [15:0] mdiv = 16'(`CMSP_DIV_DEFAULT);
  logic [3:0] lines_n = 4'hF;
  logic bad = 1'b0;
  logic msg = 1'b0;
  logic [7:0] c;
  wire [31:0] rdat;
  wire [3:0] st_n;
  wire ack, txd, rts_n, dtr_n, rxd;
  int num_errors = 0;
  int compares = 0;
  cmsp_host cmsp_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(rdat),
    .wb_ack_o(ack), .txd_o(txd), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .rxd_i(rxd),
    .cts_n_i(st_n[0]), .dsr_n_i(st_n[1]), .dcd_n_i(st_n[2]), .ri_n_i(st_n[3]));
  cmsp_dev_model cmsp_dev_model_i (.clk_i(clk_i), .txd_i(txd), .rts_n_i(rts_n),
    .dtr_n_i(dtr_n), .rxd_o(rxd), .st_n_o(st_n), .div_i(mdiv), .st_n_i(lines_n),
    .bad_i(bad), .msg_i(msg));
  // 50 MHz clock
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    dr = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // poll for a received character; the watchdog cuts a hang
  task automatic getc();
    dr = 32'h0000_0000;
    while (dr[0] !== 1'b1) xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    xfer(1'b0, `CMSP_REG_RXD, 32'h0000_0000);
    c = dr[7:0];
  endtask
  task automatic pulse_msg();
    msg <= 1'b1;
    @(posedge clk_i);
    msg <= 1'b0;
    repeat (300) @(posedge clk_i);
  endtask
  task automatic t_reset();
    chk("pins", {29'h0, txd, rts_n, dtr_n}, 32'h0000_0007);
    xfer(1'b0, `CMSP_REG_CTRL, 32'h0000_0000);
    chk("ctrl", dr, 32'(`CMSP_DIV_DEFAULT));
    xfer(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", dr, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_echo();
    xfer(1'b1, `CMSP_REG_CTRL, 32'h0003_0000 | 32'(`CMSP_DIV_DEFAULT));
    // the pins are registered one cycle behind the control register
    @(posedge clk_i);
    chk("rts dtr", {30'h0, rts_n, dtr_n}, 32'h0000_0000);
    xfer(1'b1, `CMSP_REG_TXD, 32'h0000_00A5);
    getc();
    chk("echo", {24'h0, c}, 32'h0000_00A5);
    $display("test echo done");
  endtask
  task automatic t_rate();
    mdiv <= 16'h0010;
    xfer(1'b1, `CMSP_REG_CTRL, 32'h0003_0010);
    // shifter, output register and four fifo slots take six; the seventh drops
    for (int i = 0; i < 7; i++) xfer(1'b1, `CMSP_REG_TXD, 32'h30 + i);
    xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    chk("fifo full", {31'h0, dr[1]}, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      getc();
      chk("fast echo", {24'h0, c}, 32'h30 + i);
    end
    repeat (400) @(posedge clk_i);
    xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    chk("dropped", {31'h0, dr[0]}, 32'h0000_0000);
    $display("test rate done");
  endtask
  task automatic t_frame();
    bad <= 1'b1;
    pulse_msg();
    xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    chk("frame err", {29'h0, dr[2:0]}, 32'h0000_0006);
    bad <= 1'b0;
    xfer(1'b1, `CMSP_REG_STAT, 32'h0000_0004);
    xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    chk("err clear", {31'h0, dr[2]}, 32'h0000_0000);
    xfer(1'b1, `CMSP_REG_CTRL, 32'h0001_0010);
    pulse_msg();
    xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    chk("withheld", {31'h0, dr[0]}, 32'h0000_0000);
    xfer(1'b1, `CMSP_REG_CTRL, 32'h0003_0010);
    pulse_msg();
    getc();
    chk("message", {24'h0, c}, 32'h0000_005A);
    $display("test frame done");
  endtask
  task automatic t_lines();
    // flag lane only: the divider must keep its value
    sel <= 4'h4;
    xfer(1'b1, `CMSP_REG_CTRL, 32'h0000_FFFF);
    sel <= 4'hF;
    xfer(1'b0, `CMSP_REG_CTRL, 32'h0000_0000);
    chk("lane write", dr, 32'h0000_0010);
    for (int p = 5; p < 11; p += 5) begin
      lines_n <= 4'(p);
      repeat (4) @(posedge clk_i);
      xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
      chk("lines", {28'h0, dr[6:3]}, {28'h0, ~4'(p)});
    end
    $display("test lines done");
  endtask
  task automatic t_flow();
    // cts off: the character must wait in the fifo
    lines_n <= 4'hF;
    xfer(1'b1, `CMSP_REG_CTRL, 32'h000B_0010);
    xfer(1'b1, `CMSP_REG_TXD, 32'h0000_003C);
    repeat (40) @(posedge clk_i);
    chk("held line", {31'h0, txd}, 32'h0000_0001);
    xfer(1'b0, `CMSP_REG_STAT, 32'h0000_0000);
    chk("tx waiting", {31'h0, dr[7]}, 32'h0000_0001);
    lines_n <= 4'hE;
    getc();
    chk("flow echo", {24'h0, c}, 32'h0000_003C);
    $display("test flow done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_echo();
    t_rate();
    t_frame();
    t_lines();
    t_flow();
    stop_test();
  end
  // watchdog, well above the longest expected run
  initial begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
endmodule // tb_top
bind cmsp_host cmsp_host_asserts cmsp_host_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o), .rts_n_o(rts_n_o),
  .dtr_n_o(dtr_n_o));
